// ---- rtl/sofo_pkg.sv ----
// Constants shared by the safety output and interrupt logic
package sofo_pkg;
    // Register indices on the internal register port
    localparam logic [5:0] ADDR_FACTOR = 6'h03;
    localparam logic [5:0] ADDR_REQ = 6'h07;
    localparam logic [5:0] ADDR_CLEAR = 6'h0B;
    localparam logic [5:0] ADDR_MASK = 6'h0F;
    localparam logic [5:0] ADDR_PIN_LEVEL = 6'h15;
    // Pin-level and error-mode register fields
    localparam int PIN_IND_BIT = 5;
    localparam int PIN_EXT_BIT = 4;
    localparam int PIN_SEL_BIT = 1;
    localparam int PIN_MODE_BIT = 0;
    localparam logic [7:0] PIN_LEVEL_RESET = 8'h30;
    localparam logic [7:0] PIN_LEVEL_WMASK = 8'h33;
    // Driven pin levels while in reset: fault, control, indicator, reset out
    localparam logic [3:0] PIN_DRIVE_IDLE = 4'h2;
    // Request register fields
    localparam int REQ_TEST_BIT = 7;
    localparam int REQ_FAULT_BIT = 3;
    localparam int REQ_EXT_BIT = 2;
    localparam int REQ_IND_BIT = 1;
    localparam int REQ_RST_BIT = 0;
    localparam int FACTOR_REQ_BIT = 3;
    localparam logic [7:0] REQ_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Timing
    localparam int CLK_MHZ = 10;
    localparam int SHORT_TIMEOUT_US = 100;
    localparam int LONG_TIMEOUT_US = 200;
    localparam int CLEAR_HOLD_US = 500;
    localparam int SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_US * CLK_MHZ;
    localparam int LONG_TIMEOUT_CYC = LONG_TIMEOUT_US * CLK_MHZ;
    localparam int CLEAR_HOLD_CYC = CLEAR_HOLD_US * CLK_MHZ;
    localparam int PIN_MON_LAG = 3;
endpackage

// ---- rtl/sofo_err_mon.sv ----
// Monitor of one microcontroller error input, static or dynamic format
`timescale 1ns/1ps
module sofo_err_mon #(
    parameter int SHORT_CYC = sofo_pkg::SHORT_TIMEOUT_CYC,
    parameter int LONG_CYC = sofo_pkg::LONG_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Synchronised error input and mode
    input wire logic err_in,
    input wire logic error_signal_mode,
    input wire logic toggle_timeout_sel,
    // Result
    output logic error_det
);
    localparam int CNT_W = $clog2(LONG_CYC + 1);
    logic armed_reg;
    logic prev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic err_reg;
    wire edge_seen = err_in != prev_reg;
    // Static mode is always the short time
    wire [CNT_W-1:0] limit = (error_signal_mode && !toggle_timeout_sel) ?
        CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
    // Static counts low time, dynamic counts time since last edge
    wire restart = error_signal_mode ? edge_seen : err_in;
    assign cnt_next = (restart || !armed_reg) ? '0 :
        (cnt_reg == limit) ? cnt_reg : cnt_reg + CNT_W'(1);
    assign error_det = err_reg;

    initial begin
        if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin
            $error("sofo_err_mon: timeout counts out of range");
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
            prev_reg <= 1'b0;
            cnt_reg <= '0;
            err_reg <= 1'b0;
        end else begin
            prev_reg <= err_in;
            if (err_in) begin
                armed_reg <= 1'b1;
            end
            cnt_reg <= cnt_next;
            err_reg <= armed_reg && (cnt_next == limit);
        end
    end

    a_unarmed_quiet: assert property (@(posedge clk) disable iff (!resetn)
        !armed_reg |=> !err_reg) else $error("error flagged before arming");
endmodule

// ---- rtl/sofo_top.sv ----
// Safety output pins, error-input supervision and interrupt output
// Behaviour
// - Indicator low on I/O rail undervoltage
// - Indicator software level after first high
// - Either error input drives fault output low
// - Error pulls reset low when enabled
// - Static mode: low input is error
// - Dynamic mode: missing toggle times out
// - Monitoring starts after inputs first rise
// - Fault output low while reset low
// - External control high on start, low on reset
// - Advanced mode waits for answer monitoring
// - Masked expiry lowers control until restart
// - Closed-window trigger lowers control when enabled
// - Watchdog suspend lowers external control
// - Software control level after watchdog start
// - Static expire time fixed short
// - Interrupt factors latched and readable
// - Clear register removes latched factors
// - Masked factor never asserts interrupt
// - No reassertion for hold after clear
// - Software-settable test factor
// - Output pin misbehaviour raises own factor
// - Interrupt low while unmasked factor latched
// - Interrupt registers survive system reset
`timescale 1ns/1ps
module sofo_top #(
    parameter int CLEAR_HOLD_CYC = sofo_pkg::CLEAR_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic reg_wr_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Pins from the microcontroller and supply detector
    input wire logic mcu_error_in_a,
    input wire logic mcu_error_in_b,
    input wire logic io_rail_undervoltage_flag,
    // Readback of the output pins
    input wire logic fault_pin_sense,
    input wire logic ext_ctrl_pin_sense,
    input wire logic indicator_pin_sense,
    input wire logic reset_pin_sense,
    // Reset generator and configuration
    input wire logic reset_gen_n,
    input wire logic err_reset_en,
    // Watchdog status
    input wire logic wd_start_req,
    input wire logic wd_advanced_mode,
    input wire logic wd_qa_started,
    input wire logic wd_expiry,
    input wire logic wd_expiry_reset_mask,
    input wire logic closed_window_reset_en,
    input wire logic closed_window_trigger,
    input wire logic wd_suspended,
    // Other self-diagnosis factors
    input wire logic [2:0] selfdiag_factor_in,
    // Output pins
    output logic low_voltage_indicator_n,
    output logic safety_fault_out_n,
    output logic external_control_out,
    output logic system_reset_out_n,
    output logic interrupt_out_n
);
    localparam int HW = $clog2(CLEAR_HOLD_CYC + 1);

    // Two-flop synchronisers for all pin inputs
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    wire [6:0] pins_raw = {mcu_error_in_a, mcu_error_in_b, io_rail_undervoltage_flag,
        fault_pin_sense, ext_ctrl_pin_sense, indicator_pin_sense, reset_pin_sense};
    wire err_a_s = sync2_reg[6];
    wire err_b_s = sync2_reg[5];
    wire uv_s = sync2_reg[4];
    wire [3:0] sense_s = sync2_reg[3:0];

    // Registers
    logic [7:0] pin_level_reg;
    logic [7:0] req_reg;
    logic [7:0] req_next;
    logic [7:0] mask_reg;
    logic [HW-1:0] hold_reg;
    logic [HW-1:0] hold_next;
    logic ind_seen_reg;
    logic wd_run_reg;
    logic wd_run_next;
    logic ind_reg;
    logic fault_reg;
    logic ext_reg;
    logic rst_reg;
    logic int_reg;
    logic [7:0] rdata_reg;
    localparam int PIN_MON_LAG_IDX = sofo_pkg::PIN_MON_LAG - 1;
    logic [3:0] drv_pipe_reg [PIN_MON_LAG_IDX:0];

    // Error monitors
    logic err_a_det;
    logic err_b_det;

    sofo_err_mon u_mon_a (
        .clk(clk),
        .resetn(resetn),
        .err_in(err_a_s),
        .error_signal_mode(pin_level_reg[sofo_pkg::PIN_MODE_BIT]),
        .toggle_timeout_sel(pin_level_reg[sofo_pkg::PIN_SEL_BIT]),
        .error_det(err_a_det)
    );

    sofo_err_mon u_mon_b (
        .clk(clk),
        .resetn(resetn),
        .err_in(err_b_s),
        .error_signal_mode(pin_level_reg[sofo_pkg::PIN_MODE_BIT]),
        .toggle_timeout_sel(pin_level_reg[sofo_pkg::PIN_SEL_BIT]),
        .error_det(err_b_det)
    );

    // Decode
    wire wr_pin_level = reg_wr_en && reg_addr == sofo_pkg::ADDR_PIN_LEVEL;
    wire wr_req = reg_wr_en && reg_addr == sofo_pkg::ADDR_REQ;
    wire wr_clear = reg_wr_en && reg_addr == sofo_pkg::ADDR_CLEAR;
    wire wr_mask = reg_wr_en && reg_addr == sofo_pkg::ADDR_MASK;
    wire mcu_error = err_a_det || err_b_det;

    // Reset output
    wire rst_next = reset_gen_n && !(mcu_error && err_reset_en);

    // Fault output follows errors and reset output
    wire fault_next = !mcu_error && rst_reg;

    // Indicator: low on undervoltage, software level once it has been high
    wire ind_next = uv_s ? 1'b0 :
        ind_seen_reg ? pin_level_reg[sofo_pkg::PIN_IND_BIT] : 1'b1;

    // Watchdog-run tracking for the external control output
    wire start_ok = wd_advanced_mode ? wd_qa_started : wd_start_req;
    wire ctrl_kill = !rst_reg || wd_expiry || wd_suspended || uv_s ||
        (closed_window_reset_en && closed_window_trigger);
    assign wd_run_next = ctrl_kill ? 1'b0 : (start_ok ? 1'b1 : wd_run_reg);
    wire ext_next = wd_run_next && pin_level_reg[sofo_pkg::PIN_EXT_BIT];

    // Pin monitor: driven level, delayed to match the sense path, against readback
    wire [3:0] drv_now = {fault_reg, ext_reg, ind_reg, rst_reg};
    wire [3:0] pin_bad = drv_pipe_reg[PIN_MON_LAG_IDX] ^ sense_s;

    // Event sources for the request register
    wire [7:0] req_set = {1'b0, selfdiag_factor_in, pin_bad};
    wire test_wr = wr_req ? reg_wdata[sofo_pkg::REQ_TEST_BIT] :
        req_reg[sofo_pkg::REQ_TEST_BIT];
    wire [7:0] req_clr = wr_clear ? reg_wdata : 8'h00;
    always_comb begin
        req_next = (req_reg & ~req_clr) | req_set;
        req_next[sofo_pkg::REQ_TEST_BIT] = test_wr || req_set[sofo_pkg::REQ_TEST_BIT];
        if (wr_clear && reg_wdata[sofo_pkg::REQ_TEST_BIT] && !wr_req) begin
            req_next[sofo_pkg::REQ_TEST_BIT] = 1'b0;
        end
    end

    // Hold-off after a clear
    assign hold_next = wr_clear ? HW'(CLEAR_HOLD_CYC) :
        (hold_reg != '0) ? hold_reg - HW'(1) : hold_reg;
    wire [7:0] live = req_next & ~mask_reg;
    wire int_next = !((|live) && hold_next == '0);

    // Read data
    wire [7:0] factor_val = {4'h0, |req_reg, 3'b000};
    wire [7:0] rd_mux = (reg_addr == sofo_pkg::ADDR_FACTOR) ? factor_val :
        (reg_addr == sofo_pkg::ADDR_REQ) ? req_reg :
        (reg_addr == sofo_pkg::ADDR_MASK) ? mask_reg :
        (reg_addr == sofo_pkg::ADDR_PIN_LEVEL) ? pin_level_reg : 8'h00;

    initial begin
        if (CLEAR_HOLD_CYC < 8) begin
            $error("sofo_top: CLEAR_HOLD_CYC must be at least eight");
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Sense bits start at the reset drive levels, so no false mismatch
            sync1_reg <= {3'b000, sofo_pkg::PIN_DRIVE_IDLE};
            sync2_reg <= {3'b000, sofo_pkg::PIN_DRIVE_IDLE};
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Only the device reset clears these, not the reset output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_level_reg <= sofo_pkg::PIN_LEVEL_RESET;
            req_reg <= sofo_pkg::REQ_RESET;
            mask_reg <= sofo_pkg::MASK_RESET;
            hold_reg <= '0;
        end else begin
            if (wr_pin_level) begin
                pin_level_reg <= reg_wdata & sofo_pkg::PIN_LEVEL_WMASK;
            end
            if (wr_mask) begin
                mask_reg <= reg_wdata;
            end
            req_reg <= req_next;
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ind_seen_reg <= 1'b0;
            wd_run_reg <= 1'b0;
            ind_reg <= 1'b1;
            fault_reg <= 1'b0;
            ext_reg <= 1'b0;
            rst_reg <= 1'b0;
            int_reg <= 1'b1;
            rdata_reg <= 8'h00;
        end else begin
            if (ind_reg) begin
                ind_seen_reg <= 1'b1;
            end
            wd_run_reg <= wd_run_next;
            ind_reg <= ind_next;
            fault_reg <= fault_next;
            ext_reg <= ext_next;
            rst_reg <= rst_next;
            int_reg <= int_next;
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i <= PIN_MON_LAG_IDX; i++) begin
                drv_pipe_reg[i] <= sofo_pkg::PIN_DRIVE_IDLE;
            end
        end else begin
            drv_pipe_reg[0] <= drv_now;
            for (int i = 1; i <= PIN_MON_LAG_IDX; i++) begin
                drv_pipe_reg[i] <= drv_pipe_reg[i-1];
            end
        end
    end

    assign low_voltage_indicator_n = ind_reg;
    assign safety_fault_out_n = fault_reg;
    assign external_control_out = ext_reg;
    assign system_reset_out_n = rst_reg;
    assign interrupt_out_n = int_reg;
    assign reg_rdata = rdata_reg;

    // Checks
    a_uv_indicator: assert property (@(posedge clk) disable iff (!resetn)
        uv_s |=> !low_voltage_indicator_n) else $error("indicator high in undervoltage");
    a_ind_override: assert property (@(posedge clk) disable iff (!resetn)
        (!uv_s && ind_seen_reg) |=> low_voltage_indicator_n ==
        $past(pin_level_reg[sofo_pkg::PIN_IND_BIT])) else $error("indicator override lost");
    a_err_fault: assert property (@(posedge clk) disable iff (!resetn)
        mcu_error |=> !safety_fault_out_n) else $error("fault output missed error");
    a_err_reset: assert property (@(posedge clk) disable iff (!resetn)
        (mcu_error && err_reset_en) |=> !system_reset_out_n) else $error("reset missed");
    a_noen_reset: assert property (@(posedge clk) disable iff (!resetn)
        (reset_gen_n && !err_reset_en) |=> system_reset_out_n) else $error("stray reset");
    a_reset_fault: assert property (@(posedge clk) disable iff (!resetn)
        !system_reset_out_n |=> !safety_fault_out_n) else $error("fault high in reset");
    a_ext_kill: assert property (@(posedge clk) disable iff (!resetn)
        (wd_expiry || wd_suspended || (closed_window_reset_en && closed_window_trigger))
        |=> !external_control_out) else $error("control not lowered");
    a_ext_start: assert property (@(posedge clk) disable iff (!resetn)
        (!wd_advanced_mode && wd_start_req && !ctrl_kill &&
        pin_level_reg[sofo_pkg::PIN_EXT_BIT])
        |=> external_control_out) else $error("control not raised on start");
    a_adv_wait: assert property (@(posedge clk) disable iff (!resetn)
        (wd_advanced_mode && !wd_qa_started && !wd_run_reg) |=> !external_control_out)
        else $error("control raised before answer monitoring");
    a_mask_quiet: assert property (@(posedge clk) disable iff (!resetn)
        ((req_next & ~mask_reg) == 8'h00) |=> interrupt_out_n)
        else $error("interrupt from masked factor");
    a_clear_hold: assert property (@(posedge clk) disable iff (!resetn)
        wr_clear |=> interrupt_out_n [*8]) else $error("interrupt inside hold-off");
    a_int_level: assert property (@(posedge clk) disable iff (!resetn)
        (|live && hold_next == '0) |=> !interrupt_out_n) else $error("interrupt missing");
    a_test_factor: assert property (@(posedge clk) disable iff (!resetn)
        (wr_req && reg_wdata[sofo_pkg::REQ_TEST_BIT] && !wr_clear)
        |=> req_reg[sofo_pkg::REQ_TEST_BIT]) else $error("test factor not set");
endmodule

// ---- test/sofo_mcu_model.sv ----
// Microcontroller model driving the two error outputs
`timescale 1ns/1ps
module sofo_mcu_model (
    // Clock
    input wire logic clk,
    // Behaviour chosen by the bench
    input wire logic dyn_mode,
    input wire logic [11:0] half_period,
    input wire logic force_low_a,
    input wire logic force_low_b,
    input wire logic silent,
    // Error outputs
    output logic err_a,
    output logic err_b
);
    logic [11:0] count_reg = 12'h000;
    logic level_reg = 1'b1;
    logic wrap;
    assign wrap = (count_reg + 12'h001) >= half_period;
    // Toggle each half period; silent freezes the level
    always @(posedge clk) begin
        if (dyn_mode && !silent) begin
            count_reg <= wrap ? 12'h000 : count_reg + 12'h001;
            if (wrap) level_reg <= ~level_reg;
        end else if (!dyn_mode) begin
            count_reg <= 12'h000;
            level_reg <= 1'b1;
        end
    end
    assign err_a = level_reg && !force_low_a;
    assign err_b = level_reg && !force_low_b;
endmodule

// ---- test/sofo_top_tb_top.sv ----
// Self-checking bench for the safety output and interrupt logic
`timescale 1ns/1ps
module sofo_top_tb_top;
    localparam int HOLD = 20;
    localparam int IND = 0, FLT = 1, EXT = 2, RST = 3, INT = 4;
    logic clk = 1'b0, resetn = 1'b0, reg_wr_en = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, w;
    logic mcu_error_in_a, mcu_error_in_b, io_rail_undervoltage_flag = 1'b0;
    logic fault_pin_sense = 1'b0, ext_ctrl_pin_sense = 1'b0;
    logic indicator_pin_sense = 1'b0, reset_pin_sense = 1'b0;
    logic reset_gen_n = 1'b1, err_reset_en = 1'b0, wd_start_req = 1'b0;
    logic wd_advanced_mode = 1'b0, wd_qa_started = 1'b0, wd_expiry = 1'b0;
    logic wd_expiry_reset_mask = 1'b1, closed_window_reset_en = 1'b1;
    logic closed_window_trigger = 1'b0, wd_suspended = 1'b0;
    logic [2:0] selfdiag_factor_in = 3'h0;
    logic low_voltage_indicator_n, safety_fault_out_n, external_control_out;
    logic system_reset_out_n, interrupt_out_n;
    logic dyn = 1'b0, fla = 1'b1, flb = 1'b1, silent = 1'b0;
    logic [3:0] inv = 4'h0;
    int bad_count = 0, checks = 0, seed = 99, k;

    always #50 clk = ~clk;
    // Pin readback with one cycle of board delay; inv breaks a pin
    always @(posedge clk) begin
        fault_pin_sense <= safety_fault_out_n ^ inv[3];
        ext_ctrl_pin_sense <= external_control_out ^ inv[2];
        indicator_pin_sense <= low_voltage_indicator_n ^ inv[1];
        reset_pin_sense <= system_reset_out_n ^ inv[0];
    end

    sofo_mcu_model mcu (.clk, .dyn_mode(dyn), .half_period(12'h1F4), .force_low_a(fla),
        .force_low_b(flb), .silent, .err_a(mcu_error_in_a), .err_b(mcu_error_in_b));
    sofo_top #(.CLEAR_HOLD_CYC(HOLD)) dut (.clk, .resetn, .reg_wr_en, .reg_addr, .reg_wdata,
        .reg_rdata, .mcu_error_in_a, .mcu_error_in_b, .io_rail_undervoltage_flag,
        .fault_pin_sense, .ext_ctrl_pin_sense, .indicator_pin_sense, .reset_pin_sense,
        .reset_gen_n, .err_reset_en, .wd_start_req, .wd_advanced_mode, .wd_qa_started,
        .wd_expiry, .wd_expiry_reset_mask, .closed_window_reset_en, .closed_window_trigger,
        .wd_suspended, .selfdiag_factor_in, .low_voltage_indicator_n, .safety_fault_out_n,
        .external_control_out, .system_reset_out_n, .interrupt_out_n);

    task stop_test();
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic outv(input int n);
        logic [4:0] v;
        v = {interrupt_out_n, system_reset_out_n, external_control_out, safety_fault_out_n,
            low_voltage_indicator_n};
        return v[n];
    endfunction
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    task see(input int n, input logic v, input int cyc);
        repeat (cyc) begin
            @(negedge clk);
            chk(8'(outv(n)), 8'(v));
        end
    endtask
    task wait_out(input int n, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && outv(n) !== v; i++) @(negedge clk);
        checks++;
        if (i == lim) begin
            bad_count++;
            stop_test();
        end
    endtask
    // Watchdog strobes: 0 start, 1 answer start, 2 expiry, 3 closed window, 4 suspend
    task strobe(input int n);
        @(posedge clk);
        {wd_suspended, closed_window_trigger, wd_expiry, wd_qa_started, wd_start_req}
            <= 5'(1 << n);
        @(posedge clk);
        {wd_suspended, closed_window_trigger, wd_expiry, wd_qa_started, wd_start_req} <= 5'h0;
    endtask
    task dev_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
    endtask

    initial begin
        dev_reset();
        rd(sofo_pkg::ADDR_PIN_LEVEL, sofo_pkg::PIN_LEVEL_RESET);
        rd(sofo_pkg::ADDR_MASK, sofo_pkg::MASK_RESET);
        rd(6'h3F, 8'h00);
        for (k = 0; k < 8; k++) begin
            w = 8'($random(seed));
            wr(sofo_pkg::ADDR_PIN_LEVEL, w);
            rd(sofo_pkg::ADDR_PIN_LEVEL, w & sofo_pkg::PIN_LEVEL_WMASK);
        end
        repeat (1100) @(posedge clk);
        see(FLT, 1'b1, 1);
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h30);
        wr(sofo_pkg::ADDR_CLEAR, 8'hFF);
        {fla, flb} <= 2'b00;
        see(INT, 1'b1, 1100);
        wr(sofo_pkg::ADDR_REQ, 8'h80);
        wait_out(INT, 1'b0, 4);
        rd(sofo_pkg::ADDR_FACTOR, 8'h08);
        wr(sofo_pkg::ADDR_MASK, 8'h80);
        wait_out(INT, 1'b1, 4);
        wr(sofo_pkg::ADDR_MASK, 8'h00);
        wait_out(INT, 1'b0, 4);
        reset_gen_n <= 1'b0;
        wait_out(RST, 1'b0, 4);
        see(FLT, 1'b0, 2);
        rd(sofo_pkg::ADDR_REQ, 8'h80);
        see(INT, 1'b0, 1);
        reset_gen_n <= 1'b1;
        wait_out(FLT, 1'b1, 6);
        wr(sofo_pkg::ADDR_REQ, 8'h00);
        wr(sofo_pkg::ADDR_CLEAR, 8'h80);
        see(INT, 1'b1, HOLD + 10);
        inv <= 4'h8;
        wait_out(INT, 1'b0, 10);
        rd(sofo_pkg::ADDR_REQ, 8'h08);
        wr(sofo_pkg::ADDR_CLEAR, 8'h08);
        wait_out(INT, 1'b1, 4);
        see(INT, 1'b1, HOLD - 8);
        wait_out(INT, 1'b0, 12);
        inv <= 4'h0;
        strobe(0);
        wait_out(EXT, 1'b1, 4);
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h20);
        wait_out(EXT, 1'b0, 4);
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h30);
        wait_out(EXT, 1'b1, 4);
        for (k = 2; k < 5; k++) begin
            strobe(k);
            wait_out(EXT, 1'b0, 4);
            see(EXT, 1'b0, 5);
            strobe(0);
            wait_out(EXT, 1'b1, 4);
        end
        wd_advanced_mode <= 1'b1;
        strobe(2);
        strobe(0);
        see(EXT, 1'b0, 6);
        strobe(1);
        wait_out(EXT, 1'b1, 4);
        selfdiag_factor_in <= 3'h5;
        rd(sofo_pkg::ADDR_REQ, 8'h58);
        selfdiag_factor_in <= 3'h0;
        io_rail_undervoltage_flag <= 1'b1;
        wait_out(IND, 1'b0, 6);
        see(EXT, 1'b0, 1);
        io_rail_undervoltage_flag <= 1'b0;
        wait_out(IND, 1'b1, 6);
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h10);
        wait_out(IND, 1'b0, 4);
        dyn <= 1'b1;
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h33);
        see(FLT, 1'b1, 3000);
        silent <= 1'b1;
        wait_out(FLT, 1'b0, 1100);
        see(RST, 1'b1, 1);
        {dyn, silent} <= 2'b00;
        dev_reset();
        err_reset_en <= 1'b1;
        wr(sofo_pkg::ADDR_PIN_LEVEL, 8'h32);
        flb <= 1'b1;
        see(FLT, 1'b1, 995);
        wait_out(FLT, 1'b0, 20);
        wait_out(RST, 1'b0, 4);
        stop_test();
    end
endmodule
